/* digipot_pkg.sv */
// constants and types for the serial potentiometer command core
// Overview of operation
// - write-protect low refuses setting updates; wiper writes still happen
// - six-bit wiper value enables exactly one of sixty-four taps
// - wiper loads by serial write, transfer from setting, or step
// - reset loads wiper and every setting register with SETTING_INIT
// - four six-bit stored settings; programming ends within 10ms
// - registers read as a byte: two zero bits, six value bits
// - programming starts only at CS rise after a complete write
// - write-in-progress flag shown while programming, read by status command
// - first byte after CS fall is address; top nibble is type code
// - address bit zero must match bus-select pin to continue
// - second byte: bits 7-4 instruction, 3-2 register pointer, 1-0 zero
// - both transfer commands complete after the instruction byte
// - setting-to-wiper is a RAM write; wiper-to-setting starts programming
// - reads, writes and status read carry a third data byte
// - increment/decrement: each SCK step moves wiper by SI direction, saturating at WIPER_MIN and WIPER_MAX
// - serial output released whenever it is not driving read data
// - decode the listed instruction codes; status byte low nibble 0001
// - read data changes on the falling SCK edge
// - pause low during SCK low suspends without resetting the sequence
// - CS high deselects; after reset wait for a CS fall
package digipot_pkg;
  localparam int          CLK_FREQ_HZ     = 20_000_000;
  localparam int          NV_PROG_TIME_MS = 10;
  localparam int          MS_PER_S        = 1000;
  // longest time: rounded down
  localparam int          NV_PROG_CYCLES  =
    NV_PROG_TIME_MS * (CLK_FREQ_HZ / MS_PER_S);
  localparam int          PROG_CNT_W      = 18;
  localparam int          VAL_W           = 6;
  localparam int          NUM_SETTINGS    = 4;
  localparam int          NUM_TAPS        = 64;
  localparam int          PIN_W           = 6;
  localparam logic [5:0]  WIPER_MAX       = 6'h3f;
  localparam logic [5:0]  WIPER_MIN       = 6'h00;
  localparam logic [5:0]  SETTING_INIT    = 6'h00;
  localparam logic [5:0]  SYNC_RESET      = 6'h00;
  localparam logic [2:0]  BIT_LAST        = 3'h7;
  localparam logic [1:0]  PAD_ZERO        = 2'h0;
  // type code value is arbitrary
  localparam logic [3:0]  DEVICE_TYPE     = 4'h9;
  localparam int          TYPE_HI         = 7;
  localparam int          TYPE_LO         = 4;
  localparam int          SEL_BIT         = 0;
  localparam int          OP_HI           = 7;
  localparam int          OP_LO           = 4;
  localparam int          PTR_HI          = 3;
  localparam int          PTR_LO          = 2;
  localparam int          MSB             = 7;
  // synchronised pin positions
  localparam int          P_SCK           = 0;
  localparam int          P_SI            = 1;
  localparam int          P_CS            = 2;
  localparam int          P_HOLD          = 3;
  localparam int          P_WP            = 4;
  localparam int          P_SEL           = 5;
  localparam logic [3:0]  OP_RD_WIPER     = 4'h9;
  localparam logic [3:0]  OP_WR_WIPER     = 4'ha;
  localparam logic [3:0]  OP_RD_SET       = 4'hb;
  localparam logic [3:0]  OP_WR_SET       = 4'hc;
  localparam logic [3:0]  OP_SET_TO_WIPER = 4'hd;
  localparam logic [3:0]  OP_WIPER_TO_SET = 4'he;
  localparam logic [3:0]  OP_STEP         = 4'h2;
  localparam logic [7:0]  STATUS_BYTE     = 8'h51;
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_ADDR   = 6'b000010,
    ST_INSTR  = 6'b000100,
    ST_DATA   = 6'b001000,
    ST_STEP   = 6'b010000,
    ST_IGNORE = 6'b100000
  } cmd_state_t;
endpackage

/* tap_link_if.sv */
// wiper position to tap decoder link
interface tap_link_if;
  logic [5:0]  position;
  logic [63:0] taps;
  modport ctrl (output position, input taps);
  modport dec  (input position, output taps);
endinterface

/* tap_decoder.sv */
// one-of-sixty-four tap switch decoder
module tap_decoder
  import digipot_pkg::*;
(
  input  wire logic clk_in,   // system clock
  input  wire logic rst_in,   // async reset, high
  tap_link_if.dec   bus       // position in, taps out
);
  logic [63:0] taps_reg;

  function automatic logic [63:0] one_hot(input logic [5:0] pos);
    logic [63:0] v;
    v = 64'h0;
    v[pos] = 1'b1;
    return v;
  endfunction

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      taps_reg <= 64'h1 << SETTING_INIT;
    else
      taps_reg <= one_hot(bus.position);
  end

  assign bus.taps = taps_reg;

  AST_ONE_TAP: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $onehot(taps_reg) && taps_reg[$past(bus.position)])
    else $error("tap decode not one-hot or wrong tap");
endmodule

/* digipot_core.sv */
// serial command core of a single-channel digital potentiometer
module digipot_core
  import digipot_pkg::*;
#(
  parameter int PROG_CYCLES = digipot_pkg::NV_PROG_CYCLES // programming
)
(
  input  wire logic        SYS_CLK_IN,  // system clock 20 MHz
  input  wire logic        RST_IN,      // async reset, high
  input  wire logic        SCK_IN,      // serial clock pin
  input  wire logic        SI_IN,       // serial data in
  input  wire logic        CS_N_IN,     // chip select, low
  input  wire logic        HOLD_N_IN,   // pause, low
  input  wire logic        WP_N_IN,     // write protect, low
  input  wire logic        BUS_SEL_IN,  // bus select pin
  output logic             SO_OUT,      // serial data out
  output logic             SO_OE_OUT,   // serial out enable, high
  output logic [5:0]       WIPER_OUT,   // wiper position
  output logic [63:0]      TAP_SEL_OUT, // tap switch enables
  output logic             WIP_OUT      // programming busy
);
  import digipot_pkg::*;

  logic [5:0]       sync1_reg;
  logic [5:0]       sync2_reg;
  logic             sck_prev_reg;
  logic             cs_prev_reg;
  cmd_state_t       state_reg;
  cmd_state_t       state_next;
  logic [2:0]       bit_cnt_reg;
  logic [7:0]       in_shift_reg;
  logic [3:0]       op_reg;
  logic [1:0]       ptr_reg;
  logic [5:0]       wiper_reg;
  logic [5:0]       setting_reg [NUM_SETTINGS];
  logic             pend_reg;
  logic [1:0]       pend_ptr_reg;
  logic [5:0]       pend_val_reg;
  logic             wip_reg;
  logic [PROG_CNT_W-1:0] prog_cnt_reg;
  logic [1:0]       prog_ptr_reg;
  logic [5:0]       prog_val_reg;
  logic [7:0]       out_shift_reg;
  logic             so_reg;
  logic             so_oe_reg;

  logic             sck_s;
  logic             si_s;
  logic             cs_n_s;
  logic             hold_n_s;
  logic             wp_n_s;
  logic             sel_s;
  logic             active;
  logic             sck_rise;
  logic             sck_fall;
  logic             cs_fall;
  logic             cs_rise;
  logic             byte_done;
  logic [7:0]       byte_in;
  logic             addr_done;
  logic             instr_done;
  logic             data_done;
  logic [3:0]       op_in;
  logic [1:0]       ptr_in;
  logic             load_out;
  logic [7:0]       out_value;
  logic             is_read;
  logic             step_evt;
  logic             prog_start;
  logic             prog_end;
  tap_link_if       tlink ();

  function automatic logic [7:0] as_byte(input logic [5:0] v);
    return {PAD_ZERO, v};
  endfunction

  function automatic logic [5:0] step_wiper(input logic [5:0] w,
                                            input logic up);
    logic [5:0] r;
    r = w;
    if (up && w != WIPER_MAX)
      r = w + 6'h01;
    else if (!up && w != WIPER_MIN)
      r = w - 6'h01;
    return r;
  endfunction

  // pin synchronisers, two flops before any use
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
    end
    else
    begin
      sync1_reg <= {BUS_SEL_IN, WP_N_IN, HOLD_N_IN, CS_N_IN, SI_IN, SCK_IN};
      sync2_reg <= sync1_reg;
    end
  end

  assign sck_s    = sync2_reg[P_SCK];
  assign si_s     = sync2_reg[P_SI];
  assign cs_n_s   = sync2_reg[P_CS];
  assign hold_n_s = sync2_reg[P_HOLD];
  assign wp_n_s   = sync2_reg[P_WP];
  assign sel_s    = sync2_reg[P_SEL];

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      sck_prev_reg <= 1'b0;
      cs_prev_reg  <= 1'b0;
    end
    else
    begin
      sck_prev_reg <= sck_s;
      cs_prev_reg  <= cs_n_s;
    end
  end

  // SCK edges count only while selected and not paused
  assign active   = !cs_n_s && hold_n_s;
  assign sck_rise = active && sck_s && !sck_prev_reg;
  assign sck_fall = active && !sck_s && sck_prev_reg;
  assign cs_fall  = !cs_n_s && cs_prev_reg;
  assign cs_rise  = cs_n_s && !cs_prev_reg;

  assign byte_in    = {in_shift_reg[6:0], si_s};
  assign byte_done  = sck_rise && bit_cnt_reg == BIT_LAST;
  assign addr_done  = byte_done && state_reg == ST_ADDR;
  assign instr_done = byte_done && state_reg == ST_INSTR;
  assign data_done  = byte_done && state_reg == ST_DATA;
  assign op_in      = byte_in[OP_HI:OP_LO];
  assign ptr_in     = byte_in[PTR_HI:PTR_LO];
  assign step_evt   = sck_rise && state_reg == ST_STEP;

  // read commands: choose the byte to shift out
  always_comb
  begin
    load_out  = 1'b0;
    out_value = 8'h00;
    if (instr_done)
    begin
      if (byte_in == STATUS_BYTE)
      begin
        load_out  = 1'b1;
        out_value = {7'h00, wip_reg};
      end
      else if (op_in == OP_RD_WIPER)
      begin
        load_out  = 1'b1;
        out_value = as_byte(wiper_reg);
      end
      else if (op_in == OP_RD_SET)
      begin
        load_out  = 1'b1;
        out_value = as_byte(setting_reg[ptr_in]);
      end
    end
  end

  // command sequencer
  always_comb
  begin
    state_next = state_reg;
    if (cs_n_s)
      state_next = ST_IDLE;
    else if (cs_fall)
      state_next = ST_ADDR;
    else if (addr_done)
    begin
      if (byte_in[TYPE_HI:TYPE_LO] == DEVICE_TYPE &&
          byte_in[SEL_BIT] == sel_s)
        state_next = ST_INSTR;
      else
        state_next = ST_IGNORE;
    end
    else if (instr_done)
    begin
      case (op_in)
        OP_RD_WIPER,
        OP_WR_WIPER,
        OP_RD_SET,
        OP_WR_SET:        state_next = ST_DATA;
        OP_STEP:          state_next = ST_STEP;
        default:          state_next = ST_IGNORE;
      endcase
      if (byte_in == STATUS_BYTE)
        state_next = ST_DATA;
    end
    else if (data_done)
      state_next = ST_IGNORE;
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      bit_cnt_reg  <= 3'h0;
      in_shift_reg <= 8'h00;
      op_reg       <= 4'h0;
      ptr_reg      <= 2'h0;
    end
    else if (cs_fall)
      bit_cnt_reg <= 3'h0;
    else if (sck_rise)
    begin
      bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      in_shift_reg <= byte_in;
      if (instr_done)
      begin
        op_reg  <= op_in;
        ptr_reg <= ptr_in;
      end
    end
  end

  assign is_read = op_reg != OP_WR_WIPER && op_reg != OP_WR_SET;

  // wiper position register
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      wiper_reg <= SETTING_INIT;
    else if (instr_done && op_in == OP_SET_TO_WIPER)
      wiper_reg <= setting_reg[ptr_in];
    else if (data_done && op_reg == OP_WR_WIPER)
      wiper_reg <= byte_in[VAL_W-1:0];
    else if (step_evt)
      wiper_reg <= step_wiper(wiper_reg, si_s);
  end

  // stored write waits for the CS rise
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      pend_reg     <= 1'b0;
      pend_ptr_reg <= 2'h0;
      pend_val_reg <= 6'h00;
    end
    else if (cs_n_s || cs_fall)
      pend_reg <= 1'b0;
    else if (instr_done && op_in == OP_WIPER_TO_SET)
    begin
      pend_reg     <= 1'b1;
      pend_ptr_reg <= ptr_in;
      pend_val_reg <= wiper_reg;
    end
    else if (data_done && op_reg == OP_WR_SET)
    begin
      pend_reg     <= 1'b1;
      pend_ptr_reg <= ptr_reg;
      pend_val_reg <= byte_in[VAL_W-1:0];
    end
  end

  // busy or protected: the stored write is dropped
  assign prog_start = cs_rise && pend_reg && wp_n_s && !wip_reg;
  assign prog_end   = wip_reg &&
                      prog_cnt_reg == PROG_CNT_W'(PROG_CYCLES - 1);

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      wip_reg      <= 1'b0;
      prog_cnt_reg <= '0;
      prog_ptr_reg <= 2'h0;
      prog_val_reg <= 6'h00;
    end
    else if (prog_start)
    begin
      wip_reg      <= 1'b1;
      prog_cnt_reg <= '0;
      prog_ptr_reg <= pend_ptr_reg;
      prog_val_reg <= pend_val_reg;
    end
    else if (prog_end)
      wip_reg <= 1'b0;
    else if (wip_reg)
      prog_cnt_reg <= prog_cnt_reg + 1'b1;
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      for (int i = 0; i < NUM_SETTINGS; i++)
        setting_reg[i] <= SETTING_INIT;
    end
    else if (prog_end)
      setting_reg[prog_ptr_reg] <= prog_val_reg;
  end

  // serial output, bits change on falling SCK
  always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      out_shift_reg <= 8'h00;
      so_reg        <= 1'b0;
      so_oe_reg     <= 1'b0;
    end
    else if (cs_n_s)
      so_oe_reg <= 1'b0;
    else if (load_out)
      out_shift_reg <= out_value;
    else if (sck_fall)
    begin
      if (state_reg == ST_DATA && is_read)
      begin
        so_reg        <= out_shift_reg[MSB];
        out_shift_reg <= {out_shift_reg[6:0], 1'b0};
        so_oe_reg     <= 1'b1;
      end
      else
        so_oe_reg <= 1'b0;
    end
  end

  assign tlink.position = wiper_reg;

  tap_decoder u_tap_decoder (
    .clk_in (SYS_CLK_IN),
    .rst_in (RST_IN),
    .bus    (tlink.dec)
  );

  assign SO_OUT      = so_reg;
  assign SO_OE_OUT   = so_oe_reg;
  assign WIPER_OUT   = wiper_reg;
  assign TAP_SEL_OUT = tlink.taps;
  assign WIP_OUT     = wip_reg;

  AST_WP_BLOCKS: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    !wp_n_s |-> !prog_start ##1 !$rose(wip_reg))
    else $error("programming started while write protected");

  AST_PROG_AT_CS_RISE: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    $rose(wip_reg) |-> $past(cs_rise) && $past(pend_reg))
    else $error("programming began without complete write and CS rise");

  AST_PROG_BOUND: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    wip_reg |-> prog_cnt_reg < PROG_CNT_W'(PROG_CYCLES))
    else $error("programming ran past its time");

  AST_WIP_STATUS: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    load_out && byte_in == STATUS_BYTE |=> out_shift_reg == 8'($past(wip_reg)))
    else $error("status byte does not carry busy flag");

  AST_ADDR_MISMATCH: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    addr_done && byte_in[SEL_BIT] != sel_s |=> state_reg == ST_IGNORE)
    else $error("command continued on bus select mismatch");

  AST_XFER_WIPER: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    instr_done && !cs_n_s && op_in == OP_SET_TO_WIPER && !prog_end
    |=> wiper_reg == setting_reg[$past(ptr_in)] && state_reg == ST_IGNORE)
    else $error("transfer to wiper did not complete");

  AST_STEP_UP: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    step_evt && si_s && wiper_reg != WIPER_MAX
    |=> wiper_reg == $past(wiper_reg) + 6'h01)
    else $error("increment step wrong");

  AST_STEP_SAT: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    step_evt && !si_s && wiper_reg == WIPER_MIN |=> wiper_reg == WIPER_MIN)
    else $error("decrement wrapped below zero");

  AST_SO_RELEASE: assert property (
    @(posedge SYS_CLK_IN) disable iff (RST_IN)
    cs_n_s ##1 cs_n_s |-> !so_oe_reg)
    else $error("serial output driven while deselected");
endmodule

/* host_spi_model.sv */
// host model: drives the serial command port, one bit per SCK period
module host_spi_model
(
  input  wire logic clk_in,     // system clock
  input  wire logic so_in,      // resolved serial data line
  output logic      sck_out,    // serial clock
  output logic      si_out,     // serial data to device
  output logic      cs_n_out,   // chip select, low
  output logic      hold_n_out  // pause, low
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sck_out    = 1'b0;
    si_out     = 1'b0;
    cs_n_out   = 1'b1;
    hold_n_out = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // so sampled late in the high phase, well after its change
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = n - 1; i >= 0; i--)
    begin
      si_out <= tx[i];
      wait_clk(4);
      sck_out <= 1'b1;
      wait_clk(4);
      rx[i] = so_in;
      sck_out <= 1'b0;
    end
  endtask

  task automatic head(input logic [3:0] typ, input logic sel,
                      input logic [7:0] instr);
    logic [7:0] rx;
    cs_n_out <= 1'b0;
    wait_clk(6);
    xfer({typ, 3'b110, sel}, 8, rx);
    xfer(instr, 8, rx);
  endtask

  // pause moves only while sck is low
  task automatic pause(input logic v);
    wait_clk(2);
    hold_n_out <= v;
    wait_clk(2);
  endtask

  // released data line no longer shows the last bit
  task automatic stop();
    wait_clk(4);
    cs_n_out <= 1'b1;
    si_out   <= ~si_out;
    wait_clk(12);
  endtask
endmodule

/* digipot_core_tb.sv */
// self-checking testbench for the potentiometer command core
module digipot_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import digipot_pkg::*;
  localparam int PROG = 400;
  logic        sys_clk, rst, wp_n, bus_sel, so_float, so_line;
  logic        sck, si, cs_n, hold_n, so, so_oe, write_in_progress_flag;
  logic [5:0]  wiper;
  logic [63:0] taps;
  int          fail_count, n_tests;

  initial
  begin
    sys_clk  = 1'b0;
    so_float = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // undriven line wanders rather than holding a value
  always @(posedge sys_clk) so_float <= ~so_float;
  assign so_line = so_oe ? so : so_float;

  digipot_core #(.PROG_CYCLES(PROG)) u_digipot_core (
    .SYS_CLK_IN (sys_clk),
    .RST_IN     (rst),
    .SCK_IN     (sck),
    .SI_IN      (si),
    .CS_N_IN    (cs_n),
    .HOLD_N_IN  (hold_n),
    .WP_N_IN    (wp_n),
    .BUS_SEL_IN (bus_sel),
    .SO_OUT     (so),
    .SO_OE_OUT  (so_oe),
    .WIPER_OUT  (wiper),
    .TAP_SEL_OUT(taps),
    .WIP_OUT    (write_in_progress_flag)
  );
  host_spi_model u_host_spi_model (
    .clk_in    (sys_clk),
    .so_in     (so_line),
    .sck_out   (sck),
    .si_out    (si),
    .cs_n_out  (cs_n),
    .hold_n_out(hold_n)
  );

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  function automatic logic [7:0] ins(input logic [3:0] op,
                                     input logic [1:0] ptr);
    return {op, ptr, PAD_ZERO};
  endfunction

  task automatic cmd(input logic [3:0] typ, input logic sel,
                     input logic [7:0] instr, input logic [7:0] data,
                     input int n, output logic [7:0] rx);
    rx = 8'h00;
    u_host_spi_model.head(typ, sel, instr);
    if (n > 0)
      u_host_spi_model.xfer(data, n, rx);
    u_host_spi_model.stop();
  endtask

  task automatic cmd3(input logic [7:0] instr, input logic [7:0] data,
                      output logic [7:0] rx);
    cmd(DEVICE_TYPE, bus_sel, instr, data, 8, rx);
  endtask

  task automatic cmd2(input logic [7:0] instr);
    logic [7:0] rx;
    cmd(DEVICE_TYPE, bus_sel, instr, 8'h00, 0, rx);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (write_in_progress_flag !== 1'b0 && k < PROG)
    begin
      @(posedge sys_clk);
      k++;
    end
    chk(64'(k < PROG), 64'h1);
  endtask

  task automatic t_reset();
    chk(wiper, SETTING_INIT);
    chk(taps, 64'h1);
    chk(write_in_progress_flag, 1'b0);
    chk(so_oe, 1'b0);
  endtask

  task automatic t_wiper();
    logic [7:0] rx;
    logic [5:0] v;
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 6'h2a : (i == 1) ? 6'h15 : 6'h3f;
      @(posedge sys_clk);
      bus_sel <= i[0];
      @(posedge sys_clk);
      cmd3(ins(OP_WR_WIPER, 2'h0), {2'b11, v}, rx);
      chk(wiper, v);
      chk(taps, 64'h1 << v);
      cmd3(ins(OP_RD_WIPER, 2'h0), 8'h00, rx);
      chk(rx, {2'b00, v});
      chk(so_oe, 1'b0);
    end
  endtask

  task automatic t_setting();
    logic [7:0] rx;
    logic [5:0] v;
    for (int p = 0; p < 4; p++)
    begin
      v = 6'h10 + 6'(p);
      cmd3(ins(OP_WR_SET, 2'(p)), {2'b00, v}, rx);
      chk(write_in_progress_flag, 1'b1);
      cmd3(STATUS_BYTE, 8'h00, rx);
      chk(rx, 8'h01);
      wait_idle();
      cmd3(STATUS_BYTE, 8'h00, rx);
      chk(rx, 8'h00);
      cmd3(ins(OP_RD_SET, 2'(p)), 8'h00, rx);
      chk(rx, {2'b00, v});
    end
    for (int p = 3; p >= 0; p--)
    begin
      cmd2(ins(OP_SET_TO_WIPER, 2'(p)));
      chk(wiper, 6'h10 + 6'(p));
    end
    cmd3(ins(OP_WR_WIPER, 2'h0), 8'h33, rx);
    cmd2(ins(OP_WIPER_TO_SET, 2'h2));
    chk(write_in_progress_flag, 1'b1);
    wait_idle();
    cmd3(ins(OP_RD_SET, 2'h2), 8'h00, rx);
    chk(rx, 8'h33);
  endtask

  task automatic t_protect();
    logic [7:0] rx;
    wp_n <= 1'b0;
    cmd3(ins(OP_WR_SET, 2'h1), 8'h3c, rx);
    chk(write_in_progress_flag, 1'b0);
    cmd2(ins(OP_WIPER_TO_SET, 2'h1));
    chk(write_in_progress_flag, 1'b0);
    cmd3(ins(OP_WR_WIPER, 2'h0), 8'h07, rx);
    chk(wiper, 6'h07);
    cmd3(ins(OP_RD_SET, 2'h1), 8'h00, rx);
    chk(rx, 8'h11);
    wp_n <= 1'b1;
  endtask

  task automatic t_refuse();
    logic [7:0] rx;
    cmd3(ins(OP_WR_WIPER, 2'h0), 8'h05, rx);
    cmd(~DEVICE_TYPE, bus_sel, ins(OP_WR_WIPER, 2'h0), 8'h2e, 8, rx);
    chk(wiper, 6'h05);
    cmd(DEVICE_TYPE, ~bus_sel, ins(OP_WR_WIPER, 2'h0), 8'h2e, 8, rx);
    chk(wiper, 6'h05);
    cmd(DEVICE_TYPE, bus_sel, ins(OP_WR_WIPER, 2'h0), 8'h2e, 5, rx);
    chk(wiper, 6'h05);
    cmd(DEVICE_TYPE, bus_sel, ins(OP_WR_SET, 2'h0), 8'h2e, 5, rx);
    chk(write_in_progress_flag, 1'b0);
  endtask

  task automatic t_step();
    logic [7:0] rx;
    cmd3(ins(OP_WR_WIPER, 2'h0), 8'h3e, rx);
    cmd(DEVICE_TYPE, bus_sel, ins(OP_STEP, 2'h0), 8'hff, 3, rx);
    chk(wiper, WIPER_MAX);
    cmd3(ins(OP_WR_WIPER, 2'h0), 8'h01, rx);
    cmd(DEVICE_TYPE, bus_sel, ins(OP_STEP, 2'h0), 8'h00, 2, rx);
    chk(wiper, WIPER_MIN);
    cmd3(ins(OP_WR_WIPER, 2'h0), 8'h0a, rx);
    cmd(DEVICE_TYPE, bus_sel, ins(OP_STEP, 2'h0), 8'h05, 3, rx);
    chk(wiper, 6'h0b);
    chk(taps, 64'h1 << 11);
  endtask

  task automatic t_pause();
    logic [7:0] rx;
    u_host_spi_model.head(DEVICE_TYPE, bus_sel, ins(OP_WR_WIPER, 2'h0));
    u_host_spi_model.pause(1'b0);
    u_host_spi_model.xfer(8'hff, 8, rx);
    u_host_spi_model.pause(1'b1);
    u_host_spi_model.xfer(8'h2c, 8, rx);
    u_host_spi_model.stop();
    chk(wiper, 6'h2c);
  endtask

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end

  initial
  begin
    fail_count = 0;
    n_tests    = 0;
    rst        = 1'b1;
    wp_n       = 1'b1;
    bus_sel    = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    t_reset();
    t_wiper();
    t_setting();
    t_protect();
    t_refuse();
    t_step();
    t_pause();
    end_of_test();
  end
endmodule
